/* verilog/pmsd_top.sv */
// SECDED protected peripheral memories (32-bit and 64-bit) with status, count and injection
`timescale 1ns/10ps
module pmsd_top
    import pmsd_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic req,
    input wire logic we,
    input wire logic mem_sel,
    input wire logic from_dp,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA64_W-1:0] wdata,
    input wire logic [NMEM-1:0] irq_en,
    input wire logic [1:0] inj_sel0,
    input wire logic [1:0] inj_sel1,
    input wire logic [NMEM-1:0] clr_sb,
    input wire logic [NMEM-1:0] clr_db,
    output logic rvalid,
    output logic [DATA64_W-1:0] rdata,
    output logic bus_err,
    output logic [NMEM-1:0] sts_sb,
    output logic [NMEM-1:0] sts_db,
    output logic [CNT_W-1:0] err_cnt0,
    output logic [CNT_W-1:0] err_cnt1,
    output logic [NMEM-1:0] irq
);
    logic rst_s1_q;
    logic rst_n_q;
    logic [DATA64_W-1:0] inj_mask;
    logic [DATA64_W-1:0] wd_inj;
    logic [CHK64_W-1:0] chk32;
    logic [CHK64_W-1:0] chk64;
    logic [WORD32_W-1:0] m32_rd;
    logic [WORD64_W-1:0] m64_rd;
    logic rd1_q;
    logic sel1_q;
    logic dp1_q;
    logic [DATA64_W-1:0] raw;
    logic [CHK64_W-1:0] raw_chk;
    logic [DATA64_W+1:0] dec;
    logic dec_sgl;
    logic dec_dbl;
    logic [NMEM-1:0] ev_s;
    logic [NMEM-1:0] ev_d;
    logic rvalid_q;
    logic bus_err_q;
    logic [DATA64_W-1:0] rdata_q;
    logic [NMEM-1:0] sb_q;
    logic [NMEM-1:0] db_q;
    logic [NMEM-1:0] irq_q;
    logic [CNT_W-1:0] cnt_q [NMEM];

    // Reset is asserted at once and released two clocks later
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    always_comb begin
        unique case ((mem_sel == MEM64) ? inj_sel1 : inj_sel0)
            INJ_ONE: inj_mask = INJ_MASK1;
            INJ_TWO: inj_mask = INJ_MASK2;
            INJ_THREE: inj_mask = INJ_MASK3;
            INJ_NONE: inj_mask = '0;
        endcase
    end

    // Check bits come from clean data so the flipped bits appear as real errors
    assign wd_inj = wdata ^ inj_mask;
    assign chk32 = pmsd_check({32'h0000_0000, wdata[DATA32_W-1:0]}, DATA32_W);
    assign chk64 = pmsd_check(wdata, DATA64_W);

    pmsd_mem #(.W(WORD32_W)) u_mem32 (
        .clk(clk),
        .rst_n(rst_n_q),
        .we(req && we && (mem_sel == MEM32)),
        .re(req && !we && (mem_sel == MEM32)),
        .addr(addr),
        .wdata({chk32[CHK32_W-1:0], wd_inj[DATA32_W-1:0]}),
        .rdata(m32_rd)
    );

    pmsd_mem #(.W(WORD64_W)) u_mem64 (
        .clk(clk),
        .rst_n(rst_n_q),
        .we(req && we && (mem_sel == MEM64)),
        .re(req && !we && (mem_sel == MEM64)),
        .addr(addr),
        .wdata({chk64, wd_inj}),
        .rdata(m64_rd)
    );

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rd1_q <= 1'b0;
            sel1_q <= MEM32;
            dp1_q <= 1'b0;
        end else begin
            rd1_q <= req && !we;
            sel1_q <= mem_sel;
            dp1_q <= from_dp;
        end
    end

    assign raw = (sel1_q == MEM64) ? m64_rd[DATA64_W-1:0] : {32'h0000_0000, m32_rd[DATA32_W-1:0]};
    assign raw_chk = (sel1_q == MEM64) ? m64_rd[WORD64_W-1:DATA64_W] : {1'b0, m32_rd[WORD32_W-1:DATA32_W]};
    assign dec = pmsd_decode(raw, raw_chk, (sel1_q == MEM64) ? DATA64_W : DATA32_W);
    assign dec_sgl = rd1_q && dec[DATA64_W];
    assign dec_dbl = rd1_q && dec[DATA64_W+1];

    always_comb begin
        for (int m = 0; m < NMEM; m++) begin
            ev_s[m] = dec_sgl && (int'(sel1_q) == m);
            ev_d[m] = dec_dbl && (int'(sel1_q) == m);
        end
    end

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            bus_err_q <= 1'b0;
        end else begin
            rvalid_q <= rd1_q;
            rdata_q <= dec_dbl ? raw : dec[DATA64_W-1:0];
            bus_err_q <= dec_dbl && !dp1_q;
        end
    end

    // Set wins over a clear in the same cycle so no event is lost
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            sb_q <= '0;
            db_q <= '0;
        end else begin
            sb_q <= ev_s | (sb_q & ~clr_sb);
            db_q <= ev_d | (db_q & ~clr_db);
        end
    end

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            for (int m = 0; m < NMEM; m++) begin
                cnt_q[m] <= CNT_RST;
            end
        end else begin
            for (int m = 0; m < NMEM; m++) begin
                if ((ev_s[m] || ev_d[m]) && (cnt_q[m] != CNT_MAX)) begin
                    cnt_q[m] <= cnt_q[m] + 1'b1;
                end
            end
        end
    end

    // Interrupt is a one-cycle pulse per uncorrectable read when irq_en is set for that memory or the read comes from the datapath
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            irq_q <= '0;
        end else begin
            irq_q <= ev_d & (irq_en | {NMEM{dp1_q}});
        end
    end

    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign bus_err = bus_err_q;
    assign sts_sb = sb_q;
    assign sts_db = db_q;
    assign err_cnt0 = cnt_q[MEM32_IDX];
    assign err_cnt1 = cnt_q[MEM64_IDX];
    assign irq = irq_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n_q);

    property p_rd_latency;
        (req && !we) |-> ##2 rvalid;
    endproperty
    a_rd_latency: assert property (p_rd_latency) else $error("read answer not two cycles later");

    property p_dbl_raw;
        dec_dbl |=> (rdata == $past(raw)) && $past(dec[DATA64_W-1:0]) == $past(raw);
    endproperty
    a_dbl_raw: assert property (p_dbl_raw) else $error("double error data was altered");

    property p_bus_err;
        bus_err |-> rvalid && $past(!dp1_q) && $past(dec_dbl);
    endproperty
    a_bus_err: assert property (p_bus_err) else $error("bus error without double error on bus read");

    property p_irq_en;
        (dec_dbl && !dp1_q && irq_en[sel1_q]) |=> irq[$past(sel1_q)] && bus_err;
    endproperty
    a_irq_en: assert property (p_irq_en) else $error("enabled interrupt missing on double error");

    property p_dp_irq;
        (dec_dbl && dp1_q) |=> irq[$past(sel1_q)] && !bus_err && rvalid;
    endproperty
    a_dp_irq: assert property (p_dp_irq) else $error("datapath double error without interrupt");

    property p_cnt_sat;
        (err_cnt0 == CNT_MAX) |=> (err_cnt0 == CNT_MAX) [*2];
    endproperty
    a_cnt_sat: assert property (p_cnt_sat) else $error("counter left saturation");

    property p_cnt_inc;
        (ev_s[MEM64_IDX] && err_cnt1 != CNT_MAX) |=> err_cnt1 == $past(err_cnt1) + 8'h01;
    endproperty
    a_cnt_inc: assert property (p_cnt_inc) else $error("counter did not step on error");

    property p_sticky;
        (sts_sb[MEM32_IDX] && !clr_sb[MEM32_IDX]) |=> sts_sb[MEM32_IDX];
    endproperty
    a_sticky: assert property (p_sticky) else $error("single flag dropped without clear");

    property p_set_wins;
        (ev_d[MEM32_IDX] && clr_db[MEM32_IDX]) |=> sts_db[MEM32_IDX];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("clear beat a same-cycle double error");

    property p_no_irq;
        !dec_dbl |=> irq == '0;
    endproperty
    a_no_irq: assert property (p_no_irq) else $error("interrupt without double error");

    c_single: cover property (dec_sgl ##1 rvalid);
    c_bus_dbl: cover property (dec_dbl && !dp1_q ##1 bus_err);
    c_dp_dbl: cover property (dec_dbl && dp1_q ##1 irq != '0);
    c_sat: cover property (err_cnt1 == CNT_MAX);
endmodule

/* common/pmsd_pkg.sv */
// Shared constants and SECDED coding functions for the protected peripheral memories
package pmsd_pkg;
    localparam int DATA32_W = 32;
    localparam int DATA64_W = 64;
    localparam int CHK32_W = 7;
    localparam int CHK64_W = 8;
    localparam int WORD32_W = DATA32_W + CHK32_W;
    localparam int WORD64_W = DATA64_W + CHK64_W;
    localparam int ADDR_W = 4;
    localparam int DEPTH = 16;
    localparam int CNT_W = 8;
    localparam int NMEM = 2;
    localparam int MEM32_IDX = 0;
    localparam int MEM64_IDX = 1;
    localparam int HAM_W = 7;
    localparam int MAXPOS32 = WORD32_W - 1;
    localparam int MAXPOS64 = WORD64_W - 1;
    localparam logic MEM32 = 1'b0;
    localparam logic MEM64 = 1'b1;
    localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;
    localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
    localparam logic [1:0] INJ_NONE = 2'h0;
    localparam logic [1:0] INJ_ONE = 2'h1;
    localparam logic [1:0] INJ_TWO = 2'h2;
    localparam logic [1:0] INJ_THREE = 2'h3;
    localparam logic [DATA64_W-1:0] INJ_MASK1 = 64'h0000_0000_0000_0001;
    localparam logic [DATA64_W-1:0] INJ_MASK2 = 64'h0000_0000_0000_0003;
    localparam logic [DATA64_W-1:0] INJ_MASK3 = 64'h0000_0000_0000_0007;

    // Hamming bits in [5:0] (32-bit) or [6:0] (64-bit) plus overall parity in bit 6 (32-bit) or bit 7 (64-bit)
    // Upper data bits must be zero for 32-bit words
    function automatic logic [CHK64_W-1:0] pmsd_check(input logic [DATA64_W-1:0] d, input int k);
        logic [CHK64_W-1:0] c;
        logic par;
        int idx;
        c = '0;
        idx = 0;
        for (int p = 1; p < WORD64_W; p++) begin
            if (((p & (p - 1)) != 0) && (idx < k)) begin
                for (int j = 0; j < HAM_W; j++) begin
                    if (p[j]) begin
                        c[j] = c[j] ^ d[idx];
                    end
                end
                idx++;
            end
        end
        par = (^d) ^ (^c[HAM_W-1:0]);
        if (k == DATA64_W) begin
            c[CHK64_W-1] = par;
        end else begin
            c[CHK32_W-1] = par;
        end
        return c;
    endfunction

    // Returns {double, single, data}; data is corrected only for a single error
    function automatic logic [DATA64_W+1:0] pmsd_decode(input logic [DATA64_W-1:0] d,
                                                        input logic [CHK64_W-1:0] chk, input int k);
        logic [CHK64_W-1:0] calc;
        logic [HAM_W-1:0] syn;
        logic [DATA64_W-1:0] fix;
        logic ovr;
        logic sgl;
        logic dbl;
        int idx;
        int maxpos;
        calc = pmsd_check(d, k);
        syn = chk[HAM_W-1:0] ^ calc[HAM_W-1:0];
        if (k != DATA64_W) begin
            syn[HAM_W-1] = 1'b0;
        end
        maxpos = (k == DATA64_W) ? MAXPOS64 : MAXPOS32;
        ovr = (^d) ^ (^chk);
        fix = d;
        sgl = 1'b0;
        dbl = 1'b0;
        if (ovr) begin
            if (int'(syn) > maxpos) begin
                dbl = 1'b1;
            end else begin
                sgl = 1'b1;
                idx = 0;
                for (int p = 1; p < WORD64_W; p++) begin
                    if (((p & (p - 1)) != 0) && (idx < k)) begin
                        if (p == int'(syn)) begin
                            fix[idx] = ~fix[idx];
                        end
                        idx++;
                    end
                end
            end
        end else if (syn != '0) begin
            dbl = 1'b1;
        end
        return {dbl, sgl, fix};
    endfunction
endpackage

/* verilog/pmsd_mem.sv */
// Word store for one protected memory with a registered read port
`timescale 1ns/10ps
module pmsd_mem
    import pmsd_pkg::*;
#(
    parameter int W = WORD32_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic we,
    input wire logic re,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [W-1:0] wdata,
    output logic [W-1:0] rdata
);
    logic [W-1:0] mem_q [DEPTH];
    logic [W-1:0] rdata_q;

    // No reset on the array: contents are undefined until written
    always_ff @(posedge clk) begin
        if (we) begin
            mem_q[addr] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= '0;
        end else if (re) begin
            rdata_q <= mem_q[addr];
        end
    end

    assign rdata = rdata_q;
endmodule

/* sim/pmsd_master.sv */
// Model of the bus master and datapath consumer driving the memory access port
`timescale 1ns/10ps
module pmsd_master
    import pmsd_pkg::*;
(
    input wire logic clk,
    output logic req,
    output logic we,
    output logic mem_sel,
    output logic from_dp,
    output logic [ADDR_W-1:0] addr,
    output logic [DATA64_W-1:0] wdata,
    input wire logic rvalid,
    input wire logic [DATA64_W-1:0] rdata,
    input wire logic bus_err,
    input wire logic [NMEM-1:0] irq
);
    int bus_err_events = 0;

    initial begin
        req = 1'b0;
        we = 1'b0;
        mem_sel = 1'b0;
        from_dp = 1'b0;
        addr = '0;
        wdata = '0;
    end

    // Released address and data lines flip so a stale value is never read as a live one
    task automatic drop();
        req <= 1'b0;
        addr <= ~addr;
        wdata <= ~wdata;
    endtask

    task automatic wr(input logic sel, input logic [ADDR_W-1:0] a, input logic [DATA64_W-1:0] d);
        @(posedge clk);
        req <= 1'b1;
        we <= 1'b1;
        mem_sel <= sel;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        drop();
    endtask

    task automatic rd(input logic sel, input logic [ADDR_W-1:0] a, input logic dp,
                      output logic [DATA64_W-1:0] d, output logic e, output logic [NMEM-1:0] iv, output bit ok);
        ok = 1'b0;
        d = '0;
        e = 1'b0;
        iv = '0;
        @(posedge clk);
        req <= 1'b1;
        we <= 1'b0;
        mem_sel <= sel;
        addr <= a;
        from_dp <= dp;
        @(posedge clk);
        drop();
        for (int i = 0; i < 4 && !ok; i++) begin
            @(posedge clk);
            if (rvalid === 1'b1) begin
                ok = 1'b1;
                d = rdata;
                e = bus_err;
                iv = irq;
            end
        end
        // Error response counted as a bus error event
        if (ok && e === 1'b1 && !dp) bus_err_events++;
    endtask
endmodule

/* sim/pmsd_top_tb.sv */
// Self-checking bench for the protected peripheral memories
`timescale 1ns/10ps
module pmsd_top_tb
    import pmsd_pkg::*;
;
    localparam logic [63:0] D = 64'h0f1e_2d3c_4b5a_6978;
    logic clk = 1'b0;
    logic rst_b, req, we, mem_sel, from_dp, rvalid, bus_err;
    logic [ADDR_W-1:0] addr;
    logic [DATA64_W-1:0] wdata, rdata;
    logic [NMEM-1:0] irq_en, clr_sb, clr_db, sts_sb, sts_db, irq;
    logic [1:0] inj_sel0, inj_sel1;
    logic [CNT_W-1:0] err_cnt0, err_cnt1;
    logic [CNT_W-1:0] ce [2];
    int fail_count = 0;
    int cmp_count = 0;
    int nbe = 0;

    always #20 clk = ~clk;

    pmsd_top dut_u (.clk(clk), .rst_b(rst_b), .req(req), .we(we), .mem_sel(mem_sel), .from_dp(from_dp),
        .addr(addr), .wdata(wdata), .irq_en(irq_en), .inj_sel0(inj_sel0), .inj_sel1(inj_sel1),
        .clr_sb(clr_sb), .clr_db(clr_db), .rvalid(rvalid), .rdata(rdata), .bus_err(bus_err),
        .sts_sb(sts_sb), .sts_db(sts_db), .err_cnt0(err_cnt0), .err_cnt1(err_cnt1), .irq(irq));

    pmsd_master m_u (.clk(clk), .req(req), .we(we), .mem_sel(mem_sel), .from_dp(from_dp), .addr(addr),
        .wdata(wdata), .rvalid(rvalid), .rdata(rdata), .bus_err(bus_err), .irq(irq));

    task automatic report_and_stop();
        $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    function automatic logic [63:0] ex(input int i, input logic [63:0] d);
        return (i == 1) ? d : {32'h0, d[31:0]};
    endfunction

    // Counter model stops at the top value
    task automatic bump(input int i);
        ce[i] = (ce[i] == CNT_MAX) ? CNT_MAX : ce[i] + 8'h01;
    endtask

    task automatic inj(input int i, input logic [1:0] v);
        if (i == 1) inj_sel1 <= v;
        else inj_sel0 <= v;
    endtask

    task automatic rchk(input int i, input logic [3:0] a, input logic dp, input bit dc,
                        input logic [63:0] ed, input logic ee, input logic ei);
        logic [63:0] d;
        logic e;
        logic [1:0] iv;
        bit ok;
        m_u.rd(i[0], a, dp, d, e, iv, ok);
        if (!ok) begin
            fail_count++;
            $display("ERROR rvalid expected 1 seen 0");
            report_and_stop();
        end else begin
            if (dc) chk("rdata", ed, d);
            chk("bus_err", {63'h0, ee}, {63'h0, e});
            chk("irq", {63'h0, ei}, {63'h0, iv[i]});
            chk("err_cnt", {56'h0, ce[i]}, {56'h0, (i == 1) ? err_cnt1 : err_cnt0});
        end
    endtask

    task automatic clr(input int i, input bit db);
        @(posedge clk);
        if (db) clr_db <= 2'h1 << i;
        else clr_sb <= 2'h1 << i;
        @(posedge clk);
        clr_db <= '0;
        clr_sb <= '0;
        @(posedge clk);
        chk("sticky_clear", 64'h0, {63'h0, db ? sts_db[i] : sts_sb[i]});
    endtask

    initial begin
        rst_b = 1'b0;
        irq_en = '0;
        inj_sel0 = INJ_NONE;
        inj_sel1 = INJ_NONE;
        clr_sb = '0;
        clr_db = '0;
        ce[0] = CNT_RST;
        ce[1] = CNT_RST;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        chk("sts_reset", 64'h0, {60'h0, sts_sb, sts_db});
        for (int i = 0; i < 2; i++) begin
            m_u.wr(i[0], 4'h3, D);
            rchk(i, 4'h3, 1'b0, 1'b1, ex(i, D), 1'b0, 1'b0);
            inj(i, INJ_ONE);
            m_u.wr(i[0], 4'h5, D);
            inj(i, INJ_NONE);
            bump(i);
            rchk(i, 4'h5, 1'b0, 1'b1, ex(i, D), 1'b0, 1'b0);
            chk("sts_sb", 64'h1, {63'h0, sts_sb[i]});
            clr(i, 1'b0);
            for (int m = 0; m < 3; m++) begin
                irq_en <= (m == 1) ? (2'h1 << i) : 2'h0;
                inj(i, INJ_TWO);
                m_u.wr(i[0], 4'h7, D);
                inj(i, INJ_NONE);
                bump(i);
                if (m != 2) nbe++;
                rchk(i, 4'h7, m == 2, 1'b1, ex(i, D ^ INJ_MASK2), m != 2, m != 0);
                chk("sts_db", 64'h1, {63'h0, sts_db[i]});
                $display("Test double error mem %0d mode %0d done", i, m);
            end
            clr(i, 1'b1);
            inj(i, INJ_THREE);
            m_u.wr(i[0], 4'h2, D);
            inj(i, INJ_NONE);
            bump(i);
            // Flips at the three lowest data positions cancel in the syndrome: the word reads as a single error
            rchk(i, 4'h2, 1'b1, 1'b1, ex(i, D ^ INJ_MASK3), 1'b0, 1'b0);
            chk("sts_sb_three", 64'h1, {63'h0, sts_sb[i]});
            $display("Test memory %0d done", i);
        end
        chk("bus_err_events", 64'(nbe), 64'(m_u.bus_err_events));
        inj(0, INJ_TWO);
        m_u.wr(1'b0, 4'h7, D);
        inj(0, INJ_NONE);
        bump(0);
        // Clear lands on the same edge that sets the double flag
        fork
            rchk(0, 4'h7, 1'b0, 1'b1, ex(0, D ^ INJ_MASK2), 1'b1, 1'b0);
            begin
                repeat (2) @(posedge clk);
                clr_db <= 2'h1;
                @(posedge clk);
                clr_db <= 2'h0;
            end
        join
        chk("sts_db_set_wins", 64'h1, {63'h0, sts_db[0]});
        $display("Test set over clear done");
        inj(0, INJ_ONE);
        m_u.wr(1'b0, 4'h9, D);
        inj(0, INJ_NONE);
        for (int k = 0; k < 258; k++) begin
            bump(0);
            rchk(0, 4'h9, 1'b0, 1'b1, ex(0, D), 1'b0, 1'b0);
        end
        chk("err_cnt_sat", {56'h0, CNT_MAX}, {56'h0, err_cnt0});
        $display("Test saturation done");
        report_and_stop();
    end
endmodule
